//--- verilog/scm_safety_config.sv
// Safety configuration register bank with monitor limits, power-down and checksum check.
`timescale 1ns/1ns
module scm_safety_config
    import scm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [7:0] cmdWrData,
    output logic cmdDone,
    output logic cmdRefused,
    output logic [7:0] rdData,
    input wire logic diagState,
    input wire logic cfgLock,
    input wire logic monitorEnable,
    input wire logic monitorModeSelect,
    input wire logic crcEnable,
    input wire logic [3:0] deviceErrorCounter,
    output logic monitorActive,
    output logic [LIM_W-1:0] highMinCycles,
    output logic [LIM_W-1:0] lowMaxCycles,
    output logic [LIM_W-1:0] lowMinCycles,
    output logic powerDownRequest,
    output logic crcMismatch,
    output logic crcErrorFlag
);

    scm_top_state_t q;
    scm_top_state_t n;
    logic writeOk;
    logic [7:0] pwdCfgByte;
    logic [7:0] sweepByte;

    // The engine is a module of its own so its state stays apart from the bank.
    scm_crc_if crcIf ();

    scm_crc8 u_crc (
        .clk(clk),
        .rst_n(rst_n),
        .crcIf(crcIf.engine)
    );

    // Protected writes land only in the diagnostic state with the lock open.
    assign writeOk = diagState && !cfgLock;
    // Reserved bits above the enable always read back as zero.
    assign pwdCfgByte = {PWD_RSVD_VAL, q.pwdEn, q.pwdTh};

    // Byte chosen for the current checksum sweep step.
    always_comb begin
        case (q.byteIdx)
            2'h0: sweepByte = q.highMin;
            2'h1: sweepByte = q.lowMax;
            2'h2: sweepByte = q.lowMin;
            default: sweepByte = pwdCfgByte;
        endcase
    end

    // The sweep streams one byte per cycle so the check never stops while enabled.
    assign crcIf.byteData = sweepByte;
    assign crcIf.byteValid = (q.sweep == SWEEP_RUN) && crcEnable;
    assign crcIf.firstByte = (q.byteIdx == 2'h0);
    assign crcIf.lastByte = (q.byteIdx == CRC_LAST_IDX);

    // Next-state logic: command decode, sweep sequencing, limits and power-down.
    always_comb begin
        n = q;
        n.cmdDone = 1'b0;
        n.cmdRefused = 1'b0;
        n.crcMismatch = 1'b0;

        // Reads are never refused; only protected writes look at the lock.
        if (cmdValid) begin
            if (cmdCode == CMD_RD_HIGH_MIN) begin
                n.rdData = q.highMin;
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_RD_LOW_MAX) begin
                n.rdData = q.lowMax;
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_RD_LOW_MIN) begin
                n.rdData = q.lowMin;
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_RD_PWD_CFG) begin
                n.rdData = pwdCfgByte;
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_RD_CRC_EXP) begin
                n.rdData = q.crcExp;
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_RD_STATUS) begin
                n.rdData = {7'h00, q.crcErr};
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_WR_STATUS) begin
                // Writing a one clears the sticky flag; a new mismatch below wins.
                if (cmdWrData[STAT_CRC_ERR_BIT]) begin
                    n.crcErr = 1'b0;
                end
                n.cmdDone = 1'b1;
            // The status clear sits above the lock test so a locked bank can be serviced.
            end else if (is_cfg_write(cmdCode) && !writeOk) begin
                n.cmdRefused = 1'b1;
            end else if (cmdCode == CMD_WR_HIGH_MIN) begin
                n.highMin = cmdWrData;
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_WR_LOW_MAX) begin
                n.lowMax = cmdWrData;
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_WR_LOW_MIN) begin
                n.lowMin = cmdWrData;
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_WR_PWD_CFG) begin
                n.pwdEn = cmdWrData[PWD_EN_BIT];
                n.pwdTh = cmdWrData[POWERDOWN_THRESHOLD_MSB:0];
                n.cmdDone = 1'b1;
            end else if (cmdCode == CMD_WR_CRC_EXP) begin
                n.crcExp = cmdWrData;
                n.cmdDone = 1'b1;
            end else begin
                n.cmdRefused = 1'b1;
            end
        end

        // Sweep sequencer; dropping the enable restarts the next sweep from byte zero.
        // The two-bit index wraps by itself, so no end-of-sweep compare is needed.
        case (q.sweep)
            SWEEP_IDLE: begin
                n.byteIdx = 2'h0;
                if (crcEnable) begin
                    n.sweep = SWEEP_RUN;
                end
            end
            SWEEP_RUN: begin
                if (!crcEnable) begin
                    n.sweep = SWEEP_IDLE;
                    n.byteIdx = 2'h0;
                end else begin
                    n.byteIdx = q.byteIdx + 2'h1;
                end
            end
            default: begin
                n.sweep = SWEEP_IDLE;
            end
        endcase

        // Compare after the status clear so that a fresh mismatch is never lost.
        if (crcIf.crcDone && crcEnable && (crcIf.crcValue != q.crcExp)) begin
            n.crcErr = 1'b1;
            n.crcMismatch = 1'b1;
        end

        // Limits in clock cycles for the pulse measurement logic.
        // A limit lags its field by one cycle, far below one step of the limit.
        n.highMinCyc = scale_limit(q.highMin, PWM_STEP_CYC);
        n.lowMaxCyc = monitorModeSelect ? scale_limit(q.lowMax, PWM_STEP_CYC) :
            scale_limit(q.lowMax, ALT_STEP_CYC);
        n.lowMinCyc = scale_limit(q.lowMin, PWM_STEP_CYC);

        // The request is a registered level; it drops one cycle after the counter leaves the threshold.
        n.powerDown = q.pwdEn && (deviceErrorCounter == q.pwdTh);
        // Only the enable is kept here; the pulse measurement itself lives elsewhere.
        n.monActive = monitorEnable;
    end

    // All bank state apart from the checksum engine's lives in one register; power-on reset loads the documented defaults.
    // Nothing but that reset reloads the defaults, so software must rewrite them.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= TOP_RESET;
        end else begin
            q <= n;
        end
    end

    // Every output is a flip-flop of the state register, so none can glitch.
    assign cmdDone = q.cmdDone;
    assign cmdRefused = q.cmdRefused;
    assign rdData = q.rdData;
    assign monitorActive = q.monActive;
    assign highMinCycles = q.highMinCyc;
    assign lowMaxCycles = q.lowMaxCyc;
    assign lowMinCycles = q.lowMinCyc;
    assign powerDownRequest = q.powerDown;
    assign crcMismatch = q.crcMismatch;
    assign crcErrorFlag = q.crcErr;

    // Checks on the bank's observable behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_locked_write_refused: assert property (
        cmdValid && is_cfg_write(cmdCode) && !writeOk
        |=> cmdRefused && !cmdDone && $stable(q.highMin) && $stable(q.crcExp)
            && $stable(q.lowMax) && $stable(q.lowMin))
        else $error("Write outside diagnostic unlock was not refused.");

    a_read_high_min: assert property (
        cmdValid && cmdCode == CMD_RD_HIGH_MIN |=> cmdDone && rdData == $past(q.highMin))
        else $error("High-phase minimum read returned wrong data.");

    a_high_min_limit: assert property (
        cmdValid && cmdCode == CMD_WR_HIGH_MIN && writeOk
        |=> ##1 highMinCycles == scale_limit($past(cmdWrData, 2), PWM_STEP_CYC))
        else $error("High-phase minimum limit does not follow the written field.");

    a_low_max_scale: assert property (
        ##1 lowMaxCycles == ($past(monitorModeSelect)
            ? scale_limit($past(q.lowMax), PWM_STEP_CYC)
            : scale_limit($past(q.lowMax), ALT_STEP_CYC)))
        else $error("Low-phase maximum limit uses the wrong step.");

    a_low_min_scale: assert property (
        ##1 lowMinCycles == scale_limit($past(q.lowMin), PWM_STEP_CYC))
        else $error("Low-phase minimum limit is wrong.");

    a_powerdown_trip: assert property (
        q.pwdEn && deviceErrorCounter == q.pwdTh |=> powerDownRequest)
        else $error("Power-down not requested at threshold.");

    a_powerdown_off: assert property (
        !q.pwdEn |=> !powerDownRequest)
        else $error("Power-down requested while disabled.");

    a_pwd_reserved_zero: assert property (
        cmdValid && cmdCode == CMD_RD_PWD_CFG |=> rdData[7:5] == 3'h0
            && rdData[3:0] == $past(q.pwdTh))
        else $error("Power-down register read is wrong.");

    a_crc_store: assert property (
        cmdValid && cmdCode == CMD_WR_CRC_EXP && writeOk
        |=> cmdDone ##1 (cmdValid && cmdCode == CMD_RD_CRC_EXP)
        |=> rdData == $past(cmdWrData, 3))
        else $error("Expected checksum not stored.");

    a_crc_sweep_ends: assert property (
        crcEnable [*6] |-> ##[0:4] crcIf.crcDone)
        else $error("Checksum sweep did not finish while enabled.");

    a_monitor_follows: assert property (
        ##1 monitorActive == $past(monitorEnable))
        else $error("Monitor activity does not follow its enable.");

    a_mismatch_sticky: assert property (
        crcIf.crcDone && crcEnable && crcIf.crcValue != q.crcExp
        |=> crcMismatch && crcErrorFlag)
        else $error("Checksum mismatch not reported.");

    // Command answers, write landing and status flag behaviour.
    a_cmd_answered: assert property (
        cmdValid |=> cmdDone || cmdRefused)
        else $error("Command left without an answer.");

    a_unknown_refused: assert property (
        cmdValid && (cmdCode < CMD_RD_HIGH_MIN || cmdCode > CMD_WR_STATUS)
        |=> cmdRefused && !cmdDone)
        else $error("Unknown command was not refused.");

    a_write_keeps_rd: assert property (
        cmdValid && is_cfg_write(cmdCode) |=> $stable(rdData))
        else $error("A write disturbed the read data.");

    a_high_min_write: assert property (
        cmdValid && cmdCode == CMD_WR_HIGH_MIN && writeOk
        |=> cmdDone && q.highMin == $past(cmdWrData))
        else $error("High-phase minimum write did not land.");

    a_low_max_write: assert property (
        cmdValid && cmdCode == CMD_WR_LOW_MAX && writeOk
        |=> cmdDone && q.lowMax == $past(cmdWrData))
        else $error("Low-phase maximum write did not land.");

    a_low_min_write: assert property (
        cmdValid && cmdCode == CMD_WR_LOW_MIN && writeOk
        |=> cmdDone && q.lowMin == $past(cmdWrData))
        else $error("Low-phase minimum write did not land.");

    a_pwd_write: assert property (
        cmdValid && cmdCode == CMD_WR_PWD_CFG && writeOk
        |=> cmdDone && q.pwdEn == $past(cmdWrData[PWD_EN_BIT])
            && q.pwdTh == $past(cmdWrData[POWERDOWN_THRESHOLD_MSB:0]))
        else $error("Power-down configuration write did not land.");

    a_no_compare_off: assert property (
        !crcEnable |=> !crcMismatch)
        else $error("Checksum compared while the check was off.");

    a_read_status: assert property (
        cmdValid && cmdCode == CMD_RD_STATUS |=> rdData == {7'h00, $past(q.crcErr)})
        else $error("Status read does not show the sticky flag.");

    a_status_clear: assert property (
        cmdValid && cmdCode == CMD_WR_STATUS && cmdWrData[STAT_CRC_ERR_BIT] && !crcIf.crcDone
        |=> !crcErrorFlag)
        else $error("Status write did not clear the sticky flag.");

    a_flag_holds: assert property (
        crcErrorFlag && !(cmdValid && cmdCode == CMD_WR_STATUS) |=> crcErrorFlag)
        else $error("Sticky flag dropped without a clear.");

    c_write_accepted: cover property (
        cmdValid && cmdCode == CMD_WR_LOW_MAX && writeOk ##1 cmdDone);
    c_write_refused: cover property (cmdValid && cmdCode == CMD_WR_PWD_CFG && cfgLock);
    c_powerdown: cover property (q.pwdEn && deviceErrorCounter == q.pwdTh);
    c_mismatch: cover property (crcMismatch);
    c_status_clear: cover property (cmdValid && cmdCode == CMD_WR_STATUS && crcErrorFlag);

endmodule

//--- verilog/scm_pkg.sv
// Package with constants, types and helpers of the safety configuration register bank.
// Functional notes
// - Config writes take effect only in diagnostic state with the configuration lock clear.
// - Every register has its own read command and its own write command.
// - High-phase minimum field is eight bits and resets to 0xa7.
// - Low-phase maximum resets to 0x3d; limit is (field+1) times 15 us or 5 us.
// - Low-phase minimum resets to 0x3c; limit is (field+1) times 15 us.
// - With enable set, power-down is requested when error counter equals threshold.
// - Threshold is four low bits resetting to 0xf; bits 7 to 5 read zero.
// - An eight-bit expected configuration checksum is stored as the host writes it.
// - Expected checksum resets to 0x96.
// - While checksum enable is set, the checksum is computed and compared continuously.
// - The error-signal monitor runs only while the monitor enable bit is set.
package scm_pkg;

    // Clock and step times.
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWM_STEP_US = 15;
    localparam int ALT_STEP_US = 5;
    localparam int PWM_STEP_CYC = (PWM_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALT_STEP_CYC = (ALT_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LIM_W = 19;

    // Reset values.
    localparam logic [7:0] HIGH_MIN_RST = 8'ha7;
    localparam logic [7:0] LOW_MAX_RST = 8'h3d;
    localparam logic [7:0] LOW_MIN_RST = 8'h3c;
    localparam logic PWD_EN_RST = 1'b0;
    localparam logic [3:0] POWERDOWN_THRESHOLD_RST = 4'hf;
    localparam logic [7:0] CRC_EXP_RST = 8'h96;

    // Field positions of the power-down configuration and status registers.
    localparam int PWD_EN_BIT = 4;
    localparam int POWERDOWN_THRESHOLD_MSB = 3;
    localparam logic [2:0] PWD_RSVD_VAL = 3'h0;
    localparam int STAT_CRC_ERR_BIT = 0;

    // Command codes, one read and one write per register.
    localparam logic [7:0] CMD_RD_HIGH_MIN = 8'h10;
    localparam logic [7:0] CMD_WR_HIGH_MIN = 8'h11;
    localparam logic [7:0] CMD_RD_LOW_MAX = 8'h12;
    localparam logic [7:0] CMD_WR_LOW_MAX = 8'h13;
    localparam logic [7:0] CMD_RD_LOW_MIN = 8'h14;
    localparam logic [7:0] CMD_WR_LOW_MIN = 8'h15;
    localparam logic [7:0] CMD_RD_PWD_CFG = 8'h16;
    localparam logic [7:0] CMD_WR_PWD_CFG = 8'h17;
    localparam logic [7:0] CMD_RD_CRC_EXP = 8'h18;
    localparam logic [7:0] CMD_WR_CRC_EXP = 8'h19;
    localparam logic [7:0] CMD_RD_STATUS = 8'h1a;
    localparam logic [7:0] CMD_WR_STATUS = 8'h1b;

    // Checksum engine settings.
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [1:0] CRC_LAST_IDX = 2'h3;

    typedef enum logic [0:0] {SWEEP_IDLE, SWEEP_RUN} scm_sweep_t;

    typedef struct packed {
        logic [7:0] highMin;
        logic [7:0] lowMax;
        logic [7:0] lowMin;
        logic pwdEn;
        logic [3:0] pwdTh;
        logic [7:0] crcExp;
        logic crcErr;
        logic [7:0] rdData;
        logic cmdDone;
        logic cmdRefused;
        logic [LIM_W-1:0] highMinCyc;
        logic [LIM_W-1:0] lowMaxCyc;
        logic [LIM_W-1:0] lowMinCyc;
        logic powerDown;
        logic monActive;
        logic crcMismatch;
        scm_sweep_t sweep;
        logic [1:0] byteIdx;
    } scm_top_state_t;

    typedef struct packed {
        logic [7:0] crcAcc;
        logic [7:0] crcValue;
        logic crcDone;
    } scm_crc_state_t;

    // One byte of an MSB-first CRC8 update.
    function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Limit in clock cycles: (field + 1) steps.
    function automatic logic [LIM_W-1:0] scale_limit(input logic [7:0] field, input int stepCyc);
        return LIM_W'((int'(field) + 1) * stepCyc);
    endfunction

    // True for the write commands that touch protected configuration.
    function automatic logic is_cfg_write(input logic [7:0] code);
        return (code == CMD_WR_HIGH_MIN) || (code == CMD_WR_LOW_MAX) ||
            (code == CMD_WR_LOW_MIN) || (code == CMD_WR_PWD_CFG) || (code == CMD_WR_CRC_EXP);
    endfunction

    localparam scm_top_state_t TOP_RESET = '{
        highMin: HIGH_MIN_RST, lowMax: LOW_MAX_RST, lowMin: LOW_MIN_RST,
        pwdEn: PWD_EN_RST, pwdTh: POWERDOWN_THRESHOLD_RST, crcExp: CRC_EXP_RST, crcErr: 1'b0,
        rdData: 8'h00, cmdDone: 1'b0, cmdRefused: 1'b0,
        highMinCyc: scale_limit(HIGH_MIN_RST, PWM_STEP_CYC),
        lowMaxCyc: scale_limit(LOW_MAX_RST, PWM_STEP_CYC),
        lowMinCyc: scale_limit(LOW_MIN_RST, PWM_STEP_CYC),
        powerDown: 1'b0, monActive: 1'b0, crcMismatch: 1'b0,
        sweep: SWEEP_IDLE, byteIdx: 2'h0};

    localparam scm_crc_state_t CRC_RESET = '{crcAcc: 8'h00, crcValue: 8'h00, crcDone: 1'b0};

endpackage

//--- verilog/scm_crc_if.sv
// Interface carrying configuration bytes to the checksum engine and its result back.
`timescale 1ns/1ns
interface scm_crc_if;
    logic [7:0] byteData;
    logic byteValid;
    logic firstByte;
    logic lastByte;
    logic [7:0] crcValue;
    logic crcDone;

    modport feeder (output byteData, output byteValid, output firstByte, output lastByte,
        input crcValue, input crcDone);
    modport engine (input byteData, input byteValid, input firstByte, input lastByte,
        output crcValue, output crcDone);
endinterface

//--- verilog/scm_crc8.sv
// Byte-serial CRC8 engine that reports the checksum of each finished sweep.
`timescale 1ns/1ns
module scm_crc8
    import scm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    scm_crc_if.engine crcIf
);

    scm_crc_state_t q;
    scm_crc_state_t n;
    logic [7:0] nxtCrc;

    // Each accepted byte folds into the accumulator; the first byte restarts from the seed.
    always_comb begin
        n = q;
        nxtCrc = crc8_byte(crcIf.firstByte ? CRC_INIT : q.crcAcc, crcIf.byteData);
        n.crcDone = 1'b0;
        if (crcIf.byteValid) begin
            n.crcAcc = nxtCrc;
            if (crcIf.lastByte) begin
                n.crcValue = nxtCrc;
                n.crcDone = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= CRC_RESET;
        end else begin
            q <= n;
        end
    end

    assign crcIf.crcValue = q.crcValue;
    assign crcIf.crcDone = q.crcDone;

    a_crc_done_cause: assert property (@(posedge clk) disable iff (!rst_n)
        crcIf.crcDone |-> $past(crcIf.byteValid && crcIf.lastByte))
        else $error("Checksum done without a last byte.");

endmodule

//--- verif/scm_host_model.sv
// Host controller model that sends single-byte commands to the safety register bank.
`timescale 1ns/1ns
module scm_host_model (
    input wire logic clk,
    output logic cmdValid,
    output logic [7:0] cmdCode,
    output logic [7:0] cmdWrData,
    input wire logic cmdDone,
    input wire logic cmdRefused,
    input wire logic [7:0] rdData
);
    // The strobe starts low so nothing is taken while reset is held.
    initial begin
        cmdValid = 1'b0;
        cmdCode = 8'h00;
        cmdWrData = 8'h00;
    end

    // One command is offered for exactly one edge and its answer is taken one cycle later.
    // Released lines show the inverse, so a design that samples stale values is caught.
    task automatic access(input logic [7:0] code, input logic [7:0] data, output logic done,
        output logic refused, output logic [7:0] rd);
        @(posedge clk);
        #1;
        cmdValid = 1'b1;
        cmdCode = code;
        cmdWrData = data;
        @(posedge clk);
        #1;
        cmdValid = 1'b0;
        cmdCode = ~code;
        cmdWrData = ~data;
        done = cmdDone;
        refused = cmdRefused;
        rd = rdData;
    endtask

    // Checksum the host computes over its chosen configuration, first byte in the top bits.
    function automatic logic [7:0] cfg_crc(input logic [31:0] cfgBytes);
        logic [7:0] c;
        c = 8'hff;
        for (int b = 3; b >= 0; b--) begin
            c = c ^ cfgBytes[b*8 +: 8];
            for (int i = 0; i < 8; i++) begin
                c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
            end
        end
        return c;
    endfunction
endmodule

//--- verif/scm_safety_config_bench.sv
// Self-checking bench for the safety configuration register bank.
`timescale 1ns/1ns
`define CHK(g, e) check_val(32'(g), 32'(e))
module scm_safety_config_bench
    import scm_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmdValid, cmdDone, cmdRefused;
    logic [7:0] cmdCode, cmdWrData, rdData;
    logic diagState = 1'b1;
    logic cfgLock = 1'b0;
    logic monitorEnable = 1'b0;
    logic monitorModeSelect = 1'b1;
    logic crcEnable = 1'b0;
    logic [3:0] deviceErrorCounter = 4'h0;
    logic monitorActive, powerDownRequest, crcMismatch, crcErrorFlag;
    logic [LIM_W-1:0] highMinCycles, lowMaxCycles, lowMinCycles;
    logic gotDone, gotRef;
    logic [7:0] gotRd, d, crc;
    logic [7:0] shadow [5];
    logic [31:0] rngState = 32'h0000_0039;
    int mismatches = 0;
    int checksDone = 0;
    int seen, r;
    localparam logic [7:0] RD_CODE [5] = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h18};
    localparam logic [7:0] RST_VAL [5] = '{8'ha7, 8'h3d, 8'h3c, 8'h0f, 8'h96};
    localparam logic [7:0] MASK [5] = '{8'hff, 8'hff, 8'hff, 8'h1f, 8'hff};

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    scm_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdWrData(cmdWrData), .cmdDone(cmdDone), .cmdRefused(cmdRefused), .rdData(rdData));

    scm_safety_config DUT (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdWrData(cmdWrData), .cmdDone(cmdDone), .cmdRefused(cmdRefused), .rdData(rdData),
        .diagState(diagState), .cfgLock(cfgLock), .monitorEnable(monitorEnable),
        .monitorModeSelect(monitorModeSelect), .crcEnable(crcEnable),
        .deviceErrorCounter(deviceErrorCounter), .monitorActive(monitorActive),
        .highMinCycles(highMinCycles), .lowMaxCycles(lowMaxCycles),
        .lowMinCycles(lowMinCycles), .powerDownRequest(powerDownRequest),
        .crcMismatch(crcMismatch), .crcErrorFlag(crcErrorFlag));

    // Four-state compare, so an unknown never counts as a match.
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Xorshift generator; the fixed start value keeps every run identical.
    function automatic logic [31:0] next_rand();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction

    // Limit in cycles is one step more than the field value.
    function automatic logic [18:0] exp_lim(input logic [7:0] f, input int stepCyc);
        return 19'((int'(f) + 1) * stepCyc);
    endfunction

    task automatic cmd(input logic [7:0] code, input logic [7:0] data);
        host.access(code, data, gotDone, gotRef, gotRd);
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check_limits();
        int lowStep;
        lowStep = monitorModeSelect ? PWM_STEP_CYC : ALT_STEP_CYC;
        `CHK(highMinCycles, exp_lim(shadow[0], PWM_STEP_CYC));
        `CHK(lowMaxCycles, exp_lim(shadow[1], lowStep));
        `CHK(lowMinCycles, exp_lim(shadow[2], PWM_STEP_CYC));
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence; a watchdog cuts a hang short long after the tests should be over.
    initial begin
        fork
            begin
                #200000;
                mismatches++;
                results();
            end
        join_none
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        `CHK({powerDownRequest, crcMismatch, crcErrorFlag, monitorActive}, 4'h0);
        for (int k = 0; k < 5; k++) begin
            shadow[k] = RST_VAL[k];
            cmd(RD_CODE[k], 8'h00);
            `CHK({gotDone, gotRef, gotRd}, {2'b10, RST_VAL[k]});
        end
        check_limits();
        $display("test reset values done");
        // Writes outside the open diagnostic window must leave every field untouched.
        for (int k = 0; k < 15; k++) begin
            diagState = (k % 3 == 2);
            cfgLock = (k % 3 != 0);
            cmd(RD_CODE[k / 3] + 8'h01, 8'(next_rand()));
            `CHK({gotDone, gotRef}, 2'b01);
            cmd(RD_CODE[k / 3], 8'h00);
            `CHK(gotRd, shadow[k / 3]);
        end
        diagState = 1'b1;
        cfgLock = 1'b0;
        $display("test locked writes done");
        // Extreme values first, then random ones, with the monitor mode taken from the generator state.
        for (int n = 0; n < 20; n++) begin
            r = n % 5;
            d = (n < 5) ? 8'hff : (n < 10) ? 8'h00 : 8'(next_rand());
            monitorModeSelect = rngState[3];
            cmd(RD_CODE[r] + 8'h01, d);
            `CHK({gotDone, gotRef}, 2'b10);
            shadow[r] = d & MASK[r];
            tick();
            check_limits();
            cmd(RD_CODE[r], 8'h00);
            `CHK(gotRd, shadow[r]);
        end
        cmd(8'h20, 8'h00);
        `CHK({gotDone, gotRef}, 2'b01);
        $display("test open writes done");
        // Every counter value against a random threshold, with the enable off then on.
        for (int n = 0; n < 32; n++) begin
            if (n % 16 == 0) begin
                d = 8'(next_rand());
                cmd(CMD_WR_PWD_CFG, {d[7:5], n[4], d[3:0]});
                shadow[3] = {3'h0, n[4], d[3:0]};
            end
            deviceErrorCounter = n[3:0];
            monitorEnable = 1'(next_rand());
            tick();
            `CHK(powerDownRequest, shadow[3][4] && (n[3:0] == shadow[3][3:0]));
            `CHK(monitorActive, monitorEnable);
        end
        $display("test power-down and monitor done");
        // A wrong expected checksum is ignored while the check is off and caught once on.
        crc = host.cfg_crc({shadow[0], shadow[1], shadow[2], shadow[3]});
        cmd(CMD_WR_CRC_EXP, crc ^ 8'h5a);
        cmd(CMD_RD_CRC_EXP, 8'h00);
        `CHK(gotRd, crc ^ 8'h5a);
        repeat (10) tick();
        `CHK(crcErrorFlag, 1'b0);
        crcEnable = 1'b1;
        seen = 0;
        repeat (20) begin
            tick();
            if (crcMismatch === 1'b1) seen++;
        end
        `CHK(seen > 0, 1'b1);
        cmd(CMD_RD_STATUS, 8'h00);
        `CHK({crcErrorFlag, gotRd[0]}, 2'b11);
        crcEnable = 1'b0;
        cfgLock = 1'b1;
        cmd(CMD_WR_STATUS, 8'h01);
        `CHK({gotDone, gotRef}, 2'b10);
        cfgLock = 1'b0;
        cmd(CMD_RD_STATUS, 8'h00);
        `CHK({crcErrorFlag, gotRd[0]}, 2'b00);
        cmd(CMD_WR_CRC_EXP, crc);
        crcEnable = 1'b1;
        seen = 0;
        repeat (20) begin
            tick();
            if (crcMismatch !== 1'b0) seen++;
        end
        `CHK({seen == 0, crcErrorFlag}, 2'b10);
        $display("test checksum done");
        results();
    end
endmodule
